// ==== inc/ddce_pkg.sv ====
// ddce_pkg: shared constants and carrier types of the drive command executor.
// assumes: a single 250 MHz clock domain and an Avalon-MM register slave.
`default_nettype none
package ddce_pkg;
  // register word offsets (byte addresses)
  localparam logic [7:0] REG_CMD     = 8'h00; // w: command code, r: status
  localparam logic [7:0] REG_PARAM   = 8'h04; // sector count, head, drive select
  localparam logic [7:0] REG_ERROR   = 8'h08; // r: error bits
  localparam logic [7:0] REG_DATA    = 8'h0C; // r: next data word (pio), w: buffer word
  localparam logic [7:0] REG_MEDIA   = 8'h10; // w: media-side event inputs
  localparam logic [7:0] REG_GEOM    = 8'h14; // r: stored geometry
  localparam logic [7:0] REG_BLKSZ   = 8'h18; // w: block size, 0 disables
  localparam logic [7:0] REG_DMA     = 8'h1C; // r: dma word, pops on read
  // command codes
  localparam logic [7:0] CMD_IDENT   = 8'hEC;
  localparam logic [7:0] CMD_IDLE    = 8'hE3;
  localparam logic [7:0] CMD_IDLE_IM = 8'hE1;
  localparam logic [7:0] CMD_GEOM    = 8'h91;
  localparam logic [3:0] CMD_RECAL   = 4'h1;  // upper nibble
  localparam logic [7:0] CMD_RDBUF   = 8'hE4;
  localparam logic [7:0] CMD_WRBUF   = 8'hE8;
  localparam logic [7:0] CMD_RDDMA   = 8'hC8;
  localparam logic [7:0] CMD_RDDMA_N = 8'hC9;
  localparam logic [7:0] CMD_RDLONG  = 8'h22;
  localparam logic [7:0] CMD_RDLNG_N = 8'h23;
  localparam logic [7:0] CMD_RDMULT  = 8'hC4;
  // status bit positions and error bit masks
  localparam int ST_BUSY = 7;
  localparam int ST_RDY  = 6;
  localparam int ST_DRQ  = 3;
  localparam int ST_ERR  = 0;
  localparam logic [7:0] ER_ABORT = 8'h04;
  localparam logic [7:0] ER_TNF   = 8'h10;
  localparam logic [7:0] ER_UNC   = 8'h40;
  localparam logic [7:0] ER_CORR  = 8'h01;
  // identify and buffer geometry
  localparam logic [15:0] BUF_TYPE      = 16'h0002;
  localparam logic [7:0]  SPACE_CODE    = 8'h20;
  localparam logic [8:0]  SECTOR_WORDS  = 9'd256;  // 512 bytes
  localparam logic [8:0]  CHECK_BYTES   = 9'd4;
  localparam logic [8:0]  SECCNT_ZERO   = 9'd256;
  localparam logic [15:0] IDLE_TICK_DIV = 16'd1000;
  localparam logic [15:0] SERIAL_NUM    = 16'h3137; // arbitrary serial digits "17"
  localparam logic [15:0] MODEL_NAME   = 16'h4444; // arbitrary model chars "DD"
  // media event word written by the drive mechanism model
  typedef struct packed {
    logic       seek_done;
    logic       seek_fail;
    logic       sector_ready;
    logic       corr_err;
    logic       unc_err;
  } ddce_media_type;
  // avalon-mm slave side
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } ddce_avs_req_type;
  typedef enum logic [6:0] {
    S_IDLE  = 7'b0000001,
    S_FILL  = 7'b0000010,
    S_SEEK  = 7'b0000100,
    S_WAITS = 7'b0001000,
    S_XFER  = 7'b0010000,
    S_CHECK = 7'b0100000,
    S_DONE  = 7'b1000000
  } ddce_state_type;
endpackage
`default_nettype wire

// ==== hw/ddce_core.sv ====
// ddce_core: drive-side executor for identify, idle, geometry, recalibrate,
// buffer, dma, long and multiple reads; assumes a host on avalon-mm.
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module ddce_core (
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      srst,
  // avalon-mm slave
  input  wire ddce_pkg::ddce_avs_req_type avs_req,
  output logic [31:0]                    avs_readdata,
  output logic                           avs_waitrequest,
  // drive pins
  output logic                           intrq,
  output logic                           dma_request_line,
  output logic                           spindle_on
);
  // module state except the buffer memory
  typedef struct packed {
    ddce_pkg::ddce_state_type st;
    logic [7:0]   cmd;
    logic [7:0]   status;
    logic [7:0]   error;
    logic [7:0]   sec_cnt;
    logic [3:0]   head;
    logic         drv;
    logic [7:0]   spt0, spt1;
    logic [3:0]   hm0, hm1;
    logic [4:0]   blk_size;
    logic [8:0]   left;      // sectors left
    logic [4:0]   in_blk;    // sectors left in block
    logic [8:0]   word;      // word index inside sector
    logic         stop_after;
    logic         irq;
    logic         spinning;
    logic         pdown_en;
    logic [15:0]  pdown_cnt;
    logic         ack;
    logic [31:0]  rdata;
  } ddce_core_state_type;

  ddce_core_state_type s_q, s_d;
  logic [15:0] buf_mem [0:255];
  logic [15:0] ident_word;
  logic        buf_we;
  logic [7:0]  buf_wa;
  logic [15:0] buf_wd;
  ddce_pkg::ddce_media_type media;
  logic        dma_mode, long_mode, mult_mode, data_phase;

  assign media = ddce_pkg::ddce_media_type'(avs_req.writedata[4:0]);
  assign dma_mode  = (s_q.cmd == ddce_pkg::CMD_RDDMA) || (s_q.cmd == ddce_pkg::CMD_RDDMA_N);
  assign long_mode = (s_q.cmd == ddce_pkg::CMD_RDLONG) || (s_q.cmd == ddce_pkg::CMD_RDLNG_N);
  assign mult_mode = (s_q.cmd == ddce_pkg::CMD_RDMULT);
  assign data_phase = (s_q.st == ddce_pkg::S_XFER) || (s_q.st == ddce_pkg::S_CHECK);

  // identify content by word index
  always_comb
  begin
    unique case (s_q.word[7:0])
      8'd1:    ident_word = 16'h0400;                   // cylinders
      8'd3:    ident_word = 16'h0010;                   // heads
      8'd6:    ident_word = {8'h00, s_q.spt0};         // sectors per track
      8'd19:   ident_word = ddce_pkg::SERIAL_NUM;      // last serial word
      8'd20:   ident_word = ddce_pkg::BUF_TYPE;
      8'd27:   ident_word = ddce_pkg::MODEL_NAME;      // first model word
      8'd51:   ident_word = 16'h0000;                   // pio mode 0 in 15-8
      8'd52:   ident_word = 16'h0000;                   // dma mode 0 in 15-8
      default:
      begin
        if ((s_q.word[7:0] >= 8'd10 && s_q.word[7:0] < 8'd19) ||
            (s_q.word[7:0] >= 8'd23 && s_q.word[7:0] < 8'd47))
          ident_word = {ddce_pkg::SPACE_CODE, ddce_pkg::SPACE_CODE};
        else
          ident_word = 16'h0000;
      end
    endcase
  end

  // buffer write port
  always_ff @(posedge ref_clk)
  begin
    if (buf_we)
      buf_mem[buf_wa] <= buf_wd;
  end

  // command sequencing and register bus
  always_comb
  begin
    s_d = s_q;
    buf_we = 1'b0;
    buf_wa = s_q.word[7:0];
    buf_wd = ident_word;
    s_d.ack = 1'b0;
    // status read releases the interrupt; a set further down still wins
    if (avs_req.read && !s_q.ack && avs_req.address == ddce_pkg::REG_CMD)
      s_d.irq = 1'b0;
    // power-down timer
    if (s_q.pdown_en && s_q.spinning)
    begin
      if (s_q.pdown_cnt == 16'h0000)
        s_d.spinning = 1'b0;
      else
        s_d.pdown_cnt = s_q.pdown_cnt - 16'd1;
    end
    unique case (s_q.st)
      ddce_pkg::S_IDLE: ;
      ddce_pkg::S_FILL:
      begin
        buf_we = 1'b1;
        s_d.word = s_q.word + 9'd1;
        if (s_q.word[7:0] == 8'hFF)
        begin
          s_d.word = 9'd0;
          s_d.status[ddce_pkg::ST_BUSY] = 1'b0;
          s_d.status[ddce_pkg::ST_DRQ] = 1'b1;
          s_d.irq = 1'b1;
          s_d.st = ddce_pkg::S_XFER;
        end
      end
      ddce_pkg::S_SEEK: ;                                 // waits for media word
      ddce_pkg::S_WAITS: ;                                // waits for sector_ready
      ddce_pkg::S_XFER, ddce_pkg::S_CHECK:
      begin
        if (dma_mode)
          s_d.status[ddce_pkg::ST_DRQ] = 1'b1;
      end
      ddce_pkg::S_DONE:
      begin
        s_d.status[ddce_pkg::ST_BUSY] = 1'b0;
        s_d.status[ddce_pkg::ST_DRQ]  = 1'b0;
        s_d.irq = 1'b1;
        s_d.st = ddce_pkg::S_IDLE;
      end
      default: s_d.st = ddce_pkg::S_IDLE;
    endcase

    if (avs_req.read && !s_q.ack)
    begin
      s_d.ack = 1'b1;
      s_d.rdata = 32'h0000_0000;
      unique case (avs_req.address)
        ddce_pkg::REG_CMD: s_d.rdata[7:0] = s_q.status;
        ddce_pkg::REG_ERROR: s_d.rdata[7:0] = s_q.error;
        ddce_pkg::REG_GEOM:
          s_d.rdata = {8'h00, s_q.hm1, s_q.spt1, s_q.hm0, s_q.spt0};
        ddce_pkg::REG_DATA, ddce_pkg::REG_DMA:
        begin
          if (data_phase && (dma_mode == (avs_req.address == ddce_pkg::REG_DMA)))
          begin
            if (s_q.st == ddce_pkg::S_CHECK)
              s_d.rdata[7:0] = buf_mem[s_q.word[7:0]][7:0]; // bytewide
            else
              s_d.rdata[15:0] = buf_mem[s_q.word[7:0]];
            s_d.word = s_q.word + 9'd1;
            if (s_q.st == ddce_pkg::S_CHECK && s_q.word == ddce_pkg::CHECK_BYTES - 9'd1)
              s_d.st = ddce_pkg::S_DONE;
            else if (s_q.st == ddce_pkg::S_XFER && s_q.word == ddce_pkg::SECTOR_WORDS - 9'd1)
            begin
              s_d.word = 9'd0;
              if (long_mode)
                s_d.st = ddce_pkg::S_CHECK;              // unchecked
              else if (s_q.cmd == ddce_pkg::CMD_IDENT || s_q.cmd == ddce_pkg::CMD_RDBUF ||
                       (!dma_mode && (s_q.left == 9'd1 ||
                                      (s_q.in_blk == 5'd1 && s_q.stop_after))))
              begin
                s_d.status[ddce_pkg::ST_DRQ] = 1'b0;     // pio end, no interrupt
                s_d.st = ddce_pkg::S_IDLE;
              end
              else if (s_q.left == 9'd1)
                s_d.st = ddce_pkg::S_DONE;
              else
              begin
                s_d.left = s_q.left - 9'd1;
                s_d.in_blk = (s_q.in_blk == 5'd1) ? s_q.blk_size : s_q.in_blk - 5'd1;
                s_d.status[ddce_pkg::ST_DRQ] = 1'b0;
                s_d.status[ddce_pkg::ST_BUSY] = 1'b1;
                s_d.st = ddce_pkg::S_WAITS;
              end
            end
          end
        end
        default: ;
      endcase
    end
    else if (avs_req.write && !s_q.ack)
    begin
      s_d.ack = 1'b1;
      unique case (avs_req.address)
        ddce_pkg::REG_PARAM:
        begin
          s_d.sec_cnt = avs_req.writedata[7:0];
          s_d.head    = avs_req.writedata[11:8];
          s_d.drv     = avs_req.writedata[12];
        end
        ddce_pkg::REG_BLKSZ: s_d.blk_size = avs_req.writedata[4:0];
        ddce_pkg::REG_DATA:
        begin
          if (s_q.cmd == ddce_pkg::CMD_WRBUF && s_q.status[ddce_pkg::ST_DRQ])
          begin
            buf_we = 1'b1;                               // same region
            buf_wd = avs_req.writedata[15:0];
            s_d.word = s_q.word + 9'd1;
            if (s_q.word[7:0] == 8'hFF)
            begin
              s_d.word = 9'd0;
              s_d.status[ddce_pkg::ST_DRQ] = 1'b0;
              s_d.irq = 1'b1;
            end
          end
        end
        ddce_pkg::REG_MEDIA:
        begin
          if (s_q.st == ddce_pkg::S_SEEK && (media.seek_done || media.seek_fail))
          begin
            if (media.seek_fail)
            begin
              s_d.error = ddce_pkg::ER_TNF;
              s_d.status[ddce_pkg::ST_ERR] = 1'b1;
            end
            s_d.st = ddce_pkg::S_DONE;                   // after seek only
          end
          else if (s_q.st == ddce_pkg::S_WAITS && media.sector_ready)
          begin
            s_d.status[ddce_pkg::ST_BUSY] = 1'b0;
            s_d.word = 9'd0;
            if (media.unc_err && dma_mode)
            begin
              s_d.error = ddce_pkg::ER_UNC;              // sector withheld
              s_d.status[ddce_pkg::ST_ERR] = 1'b1;
              s_d.st = ddce_pkg::S_DONE;
            end
            else
            begin
              s_d.status[ddce_pkg::ST_DRQ] = !dma_mode;
              s_d.st = ddce_pkg::S_XFER;
              if (!dma_mode && (!mult_mode || s_q.in_blk == s_q.blk_size))
                s_d.irq = 1'b1;                          // block start only
              if (mult_mode && (media.unc_err || media.corr_err))
              begin
                s_d.error = media.unc_err ? ddce_pkg::ER_UNC : ddce_pkg::ER_CORR;
                s_d.status[ddce_pkg::ST_ERR] = 1'b1;
                s_d.stop_after = s_q.stop_after | media.unc_err;
              end
              else if (media.unc_err && !long_mode)
              begin
                s_d.error = ddce_pkg::ER_UNC;
                s_d.status[ddce_pkg::ST_ERR] = 1'b1;
                s_d.left = 9'd1;                         // data pending, then end
              end
            end
          end
        end
        ddce_pkg::REG_CMD:
        begin
          if (s_q.st == ddce_pkg::S_IDLE)
          begin
            s_d.cmd = avs_req.writedata[7:0];
            s_d.error = 8'h00;
            s_d.status = 8'h00;
            s_d.status[ddce_pkg::ST_RDY] = 1'b1;
            s_d.status[ddce_pkg::ST_BUSY] = 1'b1;
            s_d.word = 9'd0;
            s_d.stop_after = 1'b0;
            s_d.left = (s_q.sec_cnt == 8'h00) ? ddce_pkg::SECCNT_ZERO
                                              : {1'b0, s_q.sec_cnt};
            s_d.st = ddce_pkg::S_DONE;
            if (avs_req.writedata[7:4] == ddce_pkg::CMD_RECAL)
              s_d.st = ddce_pkg::S_SEEK;
            else unique case (avs_req.writedata[7:0])
              ddce_pkg::CMD_IDENT: s_d.st = ddce_pkg::S_FILL;
              ddce_pkg::CMD_IDLE, ddce_pkg::CMD_IDLE_IM:
              begin
                s_d.spinning = 1'b1;                     // no spin-up if on
                if (avs_req.writedata[7:0] == ddce_pkg::CMD_IDLE)
                begin
                  s_d.pdown_en  = (s_q.sec_cnt != 8'h00);
                  s_d.pdown_cnt = 16'(s_q.sec_cnt) * ddce_pkg::IDLE_TICK_DIV;
                end
              end
              ddce_pkg::CMD_GEOM:
              begin
                if (s_q.drv)                             // unchecked
                begin
                  s_d.spt1 = s_q.sec_cnt;
                  s_d.hm1  = s_q.head;
                end
                else
                begin
                  s_d.spt0 = s_q.sec_cnt;
                  s_d.hm0  = s_q.head;
                end
              end
              ddce_pkg::CMD_RDBUF:
              begin
                s_d.status[ddce_pkg::ST_BUSY] = 1'b0;
                s_d.status[ddce_pkg::ST_DRQ] = 1'b1;
                s_d.irq = 1'b1;
                s_d.st = ddce_pkg::S_XFER;
              end
              ddce_pkg::CMD_WRBUF:
              begin
                s_d.status[ddce_pkg::ST_BUSY] = 1'b0;
                s_d.status[ddce_pkg::ST_DRQ] = 1'b1;
                s_d.st = ddce_pkg::S_IDLE;
              end
              ddce_pkg::CMD_RDDMA, ddce_pkg::CMD_RDDMA_N: s_d.st = ddce_pkg::S_WAITS;
              ddce_pkg::CMD_RDLONG, ddce_pkg::CMD_RDLNG_N:
              begin
                s_d.left = 9'd1;                         // single sector
                s_d.st = ddce_pkg::S_WAITS;
              end
              ddce_pkg::CMD_RDMULT:
              begin
                if (s_q.blk_size == 5'd0)
                begin
                  s_d.error = ddce_pkg::ER_ABORT;
                  s_d.status[ddce_pkg::ST_ERR] = 1'b1;
                end
                else
                begin
                  s_d.in_blk = s_q.blk_size;             // remainder last
                  s_d.st = ddce_pkg::S_WAITS;
                end
              end
              default:
              begin
                s_d.error = ddce_pkg::ER_ABORT;
                s_d.status[ddce_pkg::ST_ERR] = 1'b1;
              end
            endcase
          end
        end
        default: ;
      endcase
    end
  end

  // state register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      s_q <= '0;
      s_q.st <= ddce_pkg::S_IDLE;
      s_q.status <= 8'h40;
      s_q.blk_size <= 5'd0;
    end
    else
      s_q <= s_d;
  end

  // outputs
  assign avs_waitrequest  = (avs_req.read || avs_req.write) && !s_q.ack;
  assign avs_readdata     = s_q.rdata;
  assign intrq            = s_q.irq;
  assign dma_request_line = dma_mode && (s_q.st == ddce_pkg::S_XFER);
  assign spindle_on       = s_q.spinning;
endmodule // ddce_core
`default_nettype wire

// ==== tb/ddce_props.sv ====
// ddce_props: port assertions for the drive command executor.
// assumes: bound into ddce_core; one clock, srst synchronous high.
`timescale 1ns/100ps
`default_nettype none
module ddce_props (
  // clock and reset
  input wire logic                       ref_clk,
  input wire logic                       srst,
  // register bus
  input wire ddce_pkg::ddce_avs_req_type avs_req,
  input wire logic [31:0]                avs_readdata,
  input wire logic                       avs_waitrequest,
  // drive pins
  input wire logic                       intrq,
  input wire logic                       dma_request_line,
  input wire logic                       spindle_on
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  logic       st_done;
  logic       wr_done;
  logic [7:0] cmd;
  logic       recal_wait_q;
  logic       dma_cmd_q;
  logic       irq_q;
  logic [1:0] irq_cnt_q;
  // bus cycles at the edge the core takes them (waitrequest still high)
  assign wr_done = avs_req.write && avs_waitrequest;
  assign st_done = avs_req.read && avs_waitrequest && avs_req.address == ddce_pkg::REG_CMD;
  assign cmd = (wr_done && avs_req.address == ddce_pkg::REG_CMD) ?
               avs_req.writedata[7:0] : 8'h00;
  // pending recalibrate and interrupts seen since a dma command
  always_ff @(posedge ref_clk)
  begin
    irq_q <= intrq;
    if (srst || cmd != 8'h00)
    begin
      recal_wait_q <= !srst && cmd[7:4] == ddce_pkg::CMD_RECAL;
      dma_cmd_q    <= !srst && (cmd == ddce_pkg::CMD_RDDMA || cmd == ddce_pkg::CMD_RDDMA_N);
      irq_cnt_q    <= 2'h0;
    end
    else
    begin
      if (wr_done && avs_req.address == ddce_pkg::REG_MEDIA && avs_req.writedata[4:3] != 2'h0)
        recal_wait_q <= 1'b0;
      if (intrq && !irq_q && irq_cnt_q != 2'h3)
        irq_cnt_q <= irq_cnt_q + 2'h1;
    end
  end
  intr_hold_a: assert property (intrq && !st_done && !wr_done |=> intrq)
    else $error("interrupt dropped before a status read");
  intr_release_a: assert property (intrq && st_done |=> !intrq)
    else $error("interrupt kept after a status read");
  reset_quiet_a: assert property ($fell(srst) |-> !intrq && !dma_request_line)
    else $error("pins active right after reset");
  dma_end_intr_a: assert property ($rose(intrq) |-> !dma_request_line)
    else $error("interrupt while dma still requested");
  dma_one_intr_a: assert property (dma_cmd_q |-> irq_cnt_q <= 2'h1)
    else $error("more than one interrupt in a dma read");
  idle_intr_a: assert property ((cmd == ddce_pkg::CMD_IDLE || cmd == ddce_pkg::CMD_IDLE_IM)
    |-> ##[1:1000] intrq) else $error("idle gave no interrupt");
  idle_spin_a: assert property (cmd == ddce_pkg::CMD_IDLE && spindle_on |=> spindle_on)
    else $error("spindle stopped by idle");
  geom_intr_a: assert property (cmd == ddce_pkg::CMD_GEOM |-> ##[1:1000] intrq)
    else $error("geometry set gave no interrupt");
  recal_wait_a: assert property ($rose(intrq) |-> !recal_wait_q)
    else $error("recalibrate interrupt before seek end");
  cover property ($rose(intrq));
  cover property ($rose(dma_request_line));
  cover property (recal_wait_q ##1 !recal_wait_q);
endmodule // ddce_props
bind ddce_core ddce_props ddce_props_i (.ref_clk(ref_clk), .srst(srst), .avs_req(avs_req),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .intrq(intrq),
  .dma_request_line(dma_request_line), .spindle_on(spindle_on));
`default_nettype wire

// ==== tb/ddce_host_model.sv ====
// ddce_host_model: host adapter side, counts interrupts, decodes timing words.
// assumes: host logic sampling the drive pins on ref_clk.
`timescale 1ns/100ps
`default_nettype none
module ddce_host_model (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // drive pin
  input  wire logic intrq,
  // host view
  output var  int   irq_count
);
  logic irq_q;
  // one service call per rising interrupt
  always_ff @(posedge ref_clk)
  begin
    irq_q     <= intrq;
    irq_count <= srst ? 32'h0 : irq_count + int'(intrq && !irq_q);
  end
  // timing category from bits 15-8, unknown ones fall back to mode 0
  function automatic int timing_mode(input logic [15:0] word, input int max_mode);
    return (int'(word[15:8]) > max_mode) ? 0 : int'(word[15:8]);
  endfunction
endmodule // ddce_host_model
`default_nettype wire

// ==== tb/tb.sv ====
// tb: self-checking bench for the drive command executor.
// assumes: design, checker and host model compiled before it.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); \
    end \
  end
module tb;
  logic                       ref_clk;
  logic                       srst;
  ddce_pkg::ddce_avs_req_type avs_req;
  logic [31:0]                avs_readdata;
  logic                       avs_waitrequest;
  logic                       intrq;
  logic                       dma_request_line;
  logic                       spindle_on;
  logic [31:0]                rd;
  logic [15:0]                w [256];
  int                         failures;
  int                         check_count;
  int                         irq_count;
  // 250 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  ddce_core ddce_core_i (.ref_clk(ref_clk), .srst(srst), .avs_req(avs_req),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .intrq(intrq),
    .dma_request_line(dma_request_line), .spindle_on(spindle_on));
  ddce_host_model ddce_host_model_i (.ref_clk(ref_clk), .srst(srst), .intrq(intrq),
    .irq_count(irq_count));
  task automatic finish_test();
    $display("mismatches %0d of %0d checks", failures, check_count);
    if (failures == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic timeout();
    failures++;
    finish_test();
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic av(input logic [7:0] a, input logic wr, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    avs_req <= '{address: a, read: !wr, write: wr, writedata: d};
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 500);
    rd = avs_readdata;
    avs_req <= '{address: a, read: 1'b0, write: 1'b0, writedata: d};
    if (n >= 500)
      timeout();
  endtask
  task automatic issue(input logic [12:0] p, input logic [7:0] c);
    av(ddce_pkg::REG_PARAM, 1'b1, {19'h0, p});
    av(ddce_pkg::REG_CMD, 1'b1, {24'h0, c});
  endtask
  // wait for the interrupt, or also for a dma request
  task automatic wait_for(input logic dma);
    for (int n = 0; intrq !== 1'b1 && !(dma && dma_request_line === 1'b1); n++)
    begin
      @(posedge ref_clk);
      if (n > 3000)
        timeout();
    end
  endtask
  // busy must be clear; data request and error as given
  task automatic expect_status(input logic data_request_flag, input logic err);
    av(ddce_pkg::REG_CMD, 1'b0, 32'h0);
    `CHK(rd[7:0] & 8'h89, {4'h0, data_request_flag, 2'h0, err})
  endtask
  task automatic pull(input int n);
    for (int i = 0; i < n; i++)
    begin
      av(ddce_pkg::REG_DATA, 1'b0, 32'h0);
      w[i % 256] = rd[15:0];
    end
  endtask
  task automatic t_abort();
    issue(13'h0001, ddce_pkg::CMD_RDMULT);
    wait_for(1'b0);
    expect_status(1'b0, 1'b1);
    @(posedge ref_clk);
    `CHK(intrq, 1'b0)
    av(ddce_pkg::REG_ERROR, 1'b0, 32'h0);
    `CHK(rd[7:0], ddce_pkg::ER_ABORT)
  endtask
  task automatic t_ident();
    issue(13'h0, ddce_pkg::CMD_IDENT);
    wait_for(1'b0);
    expect_status(1'b1, 1'b0);
    pull(256);
    `CHK(w[10], 16'h2020)
    `CHK(w[19], ddce_pkg::SERIAL_NUM)
    `CHK(w[27], ddce_pkg::MODEL_NAME)
    `CHK(w[46], 16'h2020)
    `CHK(w[20] < 16'h0004, 1'b1)
    `CHK(w[255], 16'h0000)
    `CHK(ddce_host_model_i.timing_mode(w[51] | 16'h0900, 2), 0)
    `CHK(ddce_host_model_i.timing_mode(w[52] | 16'h0100, 2), 1)
    expect_status(1'b0, 1'b0);
  endtask
  // idle twice, idle immediate, geometry for drive 1 read back from REG_GEOM
  task automatic t_simple();
    logic [20:0] tbl [4] = '{{13'h0005, ddce_pkg::CMD_IDLE}, {13'h0, ddce_pkg::CMD_IDLE_IM},
                            {13'h0, ddce_pkg::CMD_IDLE}, {13'h1F00, ddce_pkg::CMD_GEOM}};
    foreach (tbl[i])
    begin
      issue(tbl[i][20:8], tbl[i][7:0]);
      wait_for(1'b0);
      expect_status(1'b0, 1'b0);
    end
    `CHK(spindle_on, 1'b1)
    av(ddce_pkg::REG_GEOM, 1'b0, 32'h0);
    `CHK(rd[23:0], 24'hF0_0000)
  endtask
  task automatic t_recal();
    for (int f = 0; f < 2; f++)
    begin
      issue(13'h0, {ddce_pkg::CMD_RECAL, 4'h0});
      repeat (40) @(posedge ref_clk);
      `CHK(intrq, 1'b0)
      av(ddce_pkg::REG_MEDIA, 1'b1, f ? 32'h08 : 32'h10); // seek failed or done
      wait_for(1'b0);
      expect_status(1'b0, f[0]);
    end
    av(ddce_pkg::REG_ERROR, 1'b0, 32'h0);
    `CHK(rd[7:0], ddce_pkg::ER_TNF)
  endtask
  task automatic t_buf();
    issue(13'h0, ddce_pkg::CMD_WRBUF);
    rd = 32'h0;
    for (int n = 0; n < 100 && rd[3] !== 1'b1; n++)
      av(ddce_pkg::REG_CMD, 1'b0, 32'h0);
    for (int i = 0; i < 256; i++)
      av(ddce_pkg::REG_DATA, 1'b1, {16'h0, 16'hA500 ^ 16'(i * 3)});
    wait_for(1'b0);
    expect_status(1'b0, 1'b0);
    issue(13'h0, ddce_pkg::CMD_RDBUF);
    wait_for(1'b0);
    expect_status(1'b1, 1'b0);
    pull(256);
    foreach (w[i])
      `CHK(w[i], 16'hA500 ^ 16'(i * 3))
    expect_status(1'b0, 1'b0);
  endtask
  // two-sector dma read, optional fault flag on the second sector
  task automatic t_dma(input logic [31:0] e, input int words);
    int got;
    int irq0;
    got = 0;
    irq0 = irq_count;
    issue(13'h0002, ddce_pkg::CMD_RDDMA);
    for (int s = 0; s < 2; s++)
    begin
      av(ddce_pkg::REG_MEDIA, 1'b1, s == 1 ? 32'h04 | e : 32'h04);
      for (int k = 0; k < 256; k++)
      begin
        wait_for(1'b1);
        if (dma_request_line === 1'b1)
        begin
          av(ddce_pkg::REG_DMA, 1'b0, 32'h0);
          got++;
        end
      end
    end
    wait_for(1'b0);
    expect_status(1'b0, e != 32'h0);
    `CHK(got, words)
    `CHK(irq_count - irq0, 1)
  endtask
  task automatic t_long();
    issue(13'h0001, ddce_pkg::CMD_RDLONG);
    av(ddce_pkg::REG_MEDIA, 1'b1, 32'h05); // sector ready with a bad check
    wait_for(1'b0);
    expect_status(1'b1, 1'b0);
    pull(256);
    for (int i = 0; i < int'(ddce_pkg::CHECK_BYTES); i++)
    begin
      av(ddce_pkg::REG_DATA, 1'b0, 32'h0);
      `CHK(rd[31:8], 24'h0)
    end
    expect_status(1'b0, 1'b0);
  endtask
  // ten sectors in blocks of four, fault flag on the first sector
  task automatic t_mult(input logic [31:0] e, input int blocks);
    int left;
    int bs;
    left = 10;
    av(ddce_pkg::REG_BLKSZ, 1'b1, 32'h4);
    issue(13'h000A, ddce_pkg::CMD_RDMULT);
    for (int b = 0; b < blocks; b++)
    begin
      bs = left < 4 ? left : 4;
      for (int s = 0; s < bs; s++)
      begin
        av(ddce_pkg::REG_MEDIA, 1'b1, (b == 0 && s == 0) ? 32'h04 | e : 32'h04);
        if (s == 0)
        begin
          wait_for(1'b0);
          expect_status(1'b1, e != 32'h0);
          av(ddce_pkg::REG_ERROR, 1'b0, 32'h0);
          if (b == 0)
            `CHK(rd[7:0], e == 32'h1 ? ddce_pkg::ER_UNC : ddce_pkg::ER_CORR)
        end
        else
          `CHK(intrq, 1'b0)
        pull(256);
      end
      left -= bs;
    end
    repeat (50) @(posedge ref_clk);
    `CHK(intrq, 1'b0)
    expect_status(1'b0, e != 32'h0);
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
  endtask
  // main sequence, ending with an abort test after a second reset
  initial
  begin
    failures = 0;
    check_count = 0;
    srst = 1'b1;
    avs_req = '0;
    do_reset();
    t_abort();
    t_ident();
    t_simple();
    t_recal();
    t_buf();
    t_dma(32'h0, 512);
    t_dma(32'h1, 256);
    t_long();
    t_mult(32'h2, 3);
    t_mult(32'h1, 1);
    do_reset();
    t_abort();
    finish_test();
  end
endmodule // tb
`default_nettype wire
